// ==== include/vss_defs.svh ====
`ifndef VSS_DEFS_SVH
`define VSS_DEFS_SVH

// clock
`define VSS_CLK_PERIOD_NS   10

// start delay before the ramp, in ns, and its clock count
`define VSS_START_DELAY_NS  1360000
`define VSS_START_DELAY_CYC (`VSS_START_DELAY_NS / `VSS_CLK_PERIOD_NS)

// power-good delay after the ramp, in ns, and its clock count
`define VSS_GOOD_DELAY_NS   85000
`define VSS_GOOD_DELAY_CYC  (`VSS_GOOD_DELAY_NS / `VSS_CLK_PERIOD_NS)

// counts in switching cycles
`define VSS_OFF_WAIT_SW     2'd2
`define VSS_OC_CONSEC_SW    4'd8
`define VSS_HICCUP_SW       4096

// voltage-id off codes
`define VSS_OFF_CODE_A      6'h3f
`define VSS_OFF_CODE_B      6'h3e

// dac scaling: one dac step is 6.25 mV, one id bit is 12.5 mV
`define VSS_DAC_STEP_UV     6250
`define VSS_VID_STEP_UV     12500
`define VSS_VID_TO_DAC      10'd2
`define VSS_VID_TOP_DAC     10'h100
`define VSS_DAC_W           9
`define VSS_DAC_MAX         10'h1ff
`define VSS_DAC_RST         9'h000

// phases, synchroniser width
`define VSS_PHASES          4
`define VSS_SYNC_W          19

`endif

// ==== include/vss_pkg.sv ====
package vss_pkg;
`include "vss_defs.svh"

	typedef enum logic [2:0] {
		VSS_ST_SHUTDOWN = 3'b000,
		VSS_ST_DELAY    = 3'b001,
		VSS_ST_RAMP     = 3'b010,
		VSS_ST_PGDLY    = 3'b011,
		VSS_ST_RUN      = 3'b100,
		VSS_ST_OFFWAIT  = 3'b101,
		VSS_ST_HICCUP   = 3'b110
	} vss_state_e;

	typedef enum logic [1:0] {
		VSS_PWM_HIZ = 2'b00,
		VSS_PWM_LOW = 2'b01,
		VSS_PWM_RUN = 2'b10
	} vss_pwm_e;

	typedef logic [`VSS_DAC_W-1:0] vss_dac_t;

endpackage

// ==== include/vss_ramp_if.sv ====
`timescale 1ns/1ps
// sequencer to ramp generator
interface vss_ramp_if;
	import vss_pkg::*;
	logic     clear;
	logic     step;
	vss_dac_t target;
	vss_dac_t dac;
	logic     done;

	modport seq (output clear, output step, output target,
		input dac, input done);
	modport ramp (input clear, input step, input target,
		output dac, output done);
endinterface

// ==== design/vss_sync.sv ====
`timescale 1ns/1ps
// three-stage input filter; output moves once stages two and three agree
module vss_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			// first stage is only read by the second
			always_ff @(posedge mclk) begin
				if (rst) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					dout[i] <= 1'b0;
				end else if (ce) begin
					s1_reg <= din[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						dout[i] <= s3_reg; // [RULE19]
				end
			end
		end
	endgenerate
endmodule

// ==== design/vss_ramp.sv ====
`timescale 1ns/1ps
`include "vss_defs.svh"
// soft-start reference dac: one step up per oscillator tick
module vss_ramp (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	vss_ramp_if.ramp  rif
);
	import vss_pkg::*;

	// step register, cleared whenever the sequencer is not regulating
	always_ff @(posedge mclk) begin
		if (rst) begin
			rif.dac <= `VSS_DAC_RST;
		end else if (ce) begin
			if (rif.clear)
				rif.dac <= `VSS_DAC_RST;
			else if (rif.step && (rif.dac < rif.target))
				rif.dac <= rif.dac + 9'h001; // [RULE8]
		end
	end

	// done flags the dac sitting on its target
	always_ff @(posedge mclk) begin
		if (rst) begin
			rif.done <= 1'b0;
		end else if (ce) begin
			rif.done <= !rif.clear && (rif.dac == rif.target); // [RULE9]
		end
	end
endmodule

// ==== design/vss_sequencer.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE1: shutdown keeps every phase output high-impedance
// RULE2: start needs reset passed, both enables, valid code
// RULE3: two off codes are invalid and latched
// RULE4: off code: two switch cycles, then disable
// RULE5: enabled with off code stays off until cycled
// RULE6: only enable or supply reset clears overvoltage
// RULE7: fixed start delay before the ramp begins
// RULE8: ramp dac one step per oscillator tick
// RULE9: ramp target is code plus offset
// RULE10: power-good rises after fixed delay past ramp
// RULE11: power-good low when off, faulted or disabled
// RULE12: undervoltage pulls power-good low
// RULE13: overvoltage trip level chosen by operating state
// RULE14: overvoltage drives outputs low, then high-impedance
// RULE15: overvoltage stops switching until enables cycle
// RULE16: average overcurrent shuts down at once
// RULE17: channel overcurrent eight cycles running shuts down
// RULE18: overcurrent hiccup 4096 cycles then retry
// RULE19: comparator inputs synchronised before use
`include "vss_defs.svh"
module vss_sequencer #(
	parameter int START_DELAY_CYC = `VSS_START_DELAY_CYC,
	parameter int GOOD_DELAY_CYC  = `VSS_GOOD_DELAY_CYC,
	parameter int HICCUP_SW       = `VSS_HICCUP_SW
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	input  wire logic                    por_ok,
	input  wire logic                    power_enable_in,
	input  wire logic                    tracking_rail_enable,
	input  wire logic [5:0]              voltage_id_code,
	input  wire logic [7:0]              dac_offset,
	input  wire logic                    output_sense_low,
	input  wire logic                    overvoltage_guard,
	input  wire logic                    remote_sense_low,
	input  wire logic                    average_phase_current,
	input  wire logic [`VSS_PHASES-1:0]  channel_overcurrent,
	input  wire logic                    switch_osc,
	input  wire logic                    ramp_osc,
	output vss_pkg::vss_pwm_e            pwm_cmd,
	output vss_pkg::vss_dac_t            dac_code,
	output logic                         power_good_out,
	output logic                         ov_level_vid,
	output logic                         off_code_latched,
	output logic                         ovp_latched,
	output logic                         latched_off,
	output logic                         oc_hiccup
);
	import vss_pkg::*;

	// true for the two codes that request the regulator off
	function automatic logic is_off_code(input logic [5:0] code);
		return (code == `VSS_OFF_CODE_A) || (code == `VSS_OFF_CODE_B);
	endfunction

	// id code to dac steps, offset added, clamped to the dac range
	function automatic vss_dac_t code_to_dac(input logic [5:0] code,
		input logic [7:0] ofs);
		logic signed [10:0] lvl;
		lvl = 11'(signed'({1'b0, `VSS_VID_TOP_DAC}))
			- 11'(signed'({1'b0, 4'h0, code} * `VSS_VID_TO_DAC))
			+ 11'(signed'(ofs));
		if (lvl < 11'sd0)
			return `VSS_DAC_RST;
		else if (lvl > 11'(signed'({1'b0, `VSS_DAC_MAX})))
			return 9'(`VSS_DAC_MAX);
		else
			return lvl[8:0];
	endfunction

	// true in states where the phases switch normally
	function automatic logic is_active(input vss_state_e st);
		return (st == VSS_ST_RAMP) || (st == VSS_ST_PGDLY)
			|| (st == VSS_ST_RUN) || (st == VSS_ST_OFFWAIT);
	endfunction

	logic [`VSS_SYNC_W-1:0] raw_in;
	logic [`VSS_SYNC_W-1:0] syn;
	logic                   pwr_s;
	logic                   vtt_s;
	logic                   por_s;
	logic                   uv_s;
	logic                   ov_s;
	logic                   avg_oc_s;
	logic [`VSS_PHASES-1:0] chan_oc_s;
	logic                   rs_low_s;
	logic                   sw_s;
	logic                   ss_s;
	logic [5:0]             vid_s;
	logic                   sw_q_reg;
	logic                   ss_q_reg;
	logic                   sw_rise;
	logic                   ss_rise;
	logic                   en_ok;
	logic                   off_now;
	logic                   oc_event;
	logic [`VSS_PHASES-1:0] chan_trip;
	vss_state_e             state_reg;
	logic [19:0]            timer_reg;
	logic [12:0]            hic_cnt_reg;
	logic [1:0]             off_cnt_reg;
	logic                   off_done;
	logic                   hic_done;
	logic                   start_done;
	logic                   good_done;
	vss_dac_t               target_reg;

	vss_ramp_if rif ();

	// every comparator result and the id pins cross in here
	assign raw_in = {voltage_id_code, ramp_osc, switch_osc,
		remote_sense_low, channel_overcurrent, average_phase_current,
		overvoltage_guard, output_sense_low, por_ok,
		tracking_rail_enable, power_enable_in};

	vss_sync #(
		.W (`VSS_SYNC_W)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.din  (raw_in),
		.dout (syn)
	); // [RULE19]

	// unpack the filtered inputs
	assign pwr_s     = syn[0];
	assign vtt_s     = syn[1];
	assign por_s     = syn[2];
	assign uv_s      = syn[3];
	assign ov_s      = syn[4];
	assign avg_oc_s  = syn[5];
	assign chan_oc_s = syn[9:6];
	assign rs_low_s  = syn[10];
	assign sw_s      = syn[11];
	assign ss_s      = syn[12];
	assign vid_s     = syn[18:13];

	// oscillator edges become single-cycle ticks
	always_ff @(posedge mclk) begin
		if (rst) begin
			sw_q_reg <= 1'b0;
			ss_q_reg <= 1'b0;
		end else if (ce) begin
			sw_q_reg <= sw_s;
			ss_q_reg <= ss_s;
		end
	end
	assign sw_rise = sw_s && !sw_q_reg;
	assign ss_rise = ss_s && !ss_q_reg;

	// all three enable conditions; dropping any one cycles the part
	assign en_ok   = por_s && pwr_s && vtt_s; // [RULE2]
	assign off_now = is_off_code(vid_s); // [RULE3]

	// per-channel run counter of consecutive over-limit switch cycles
	genvar ch;
	generate
		for (ch = 0; ch < `VSS_PHASES; ch++) begin : g_chan
			logic [3:0] cnt_reg;
			// a single cycle below the limit restarts the count
			always_ff @(posedge mclk) begin
				if (rst) begin
					cnt_reg <= 4'h0;
				end else if (ce) begin
					if (!chan_oc_s[ch] || !is_active(state_reg))
						cnt_reg <= 4'h0; // [RULE17]
					else if (sw_rise && cnt_reg < `VSS_OC_CONSEC_SW)
						cnt_reg <= cnt_reg + 4'h1; // [RULE17]
				end
			end
			assign chan_trip[ch] = (cnt_reg == `VSS_OC_CONSEC_SW);
		end
	endgenerate

	// either overcurrent scheme, only while the phases switch
	assign oc_event = is_active(state_reg)
		&& (avg_oc_s || (|chan_trip)); // [RULE16] [RULE17]

	// overvoltage latch: set from reset onward, set wins over clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			ovp_latched <= 1'b0;
		end else if (ce) begin
			if (ov_s)
				ovp_latched <= 1'b1; // [RULE13] [RULE15]
			else if (!en_ok)
				ovp_latched <= 1'b0; // [RULE6]
		end
	end

	// off-code occurrence flag, dropped once the code is gone and an enable is lost
	always_ff @(posedge mclk) begin
		if (rst) begin
			off_code_latched <= 1'b0;
		end else if (ce) begin
			if (off_now)
				off_code_latched <= 1'b1; // [RULE3]
			else if (!en_ok)
				off_code_latched <= 1'b0;
		end
	end

	// latched off: enabled into an off code, or off code while running
	always_ff @(posedge mclk) begin
		if (rst) begin
			latched_off <= 1'b0;
		end else if (ce) begin
			if (en_ok && off_now && state_reg == VSS_ST_SHUTDOWN)
				latched_off <= 1'b1; // [RULE5]
			else if (off_done)
				latched_off <= 1'b1; // [RULE4]
			else if (!en_ok)
				latched_off <= 1'b0; // [RULE5]
		end
	end

	// shared delay timer for the start and power-good waits
	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_reg <= 20'h00000;
		end else if (ce) begin
			if ((state_reg == VSS_ST_DELAY && !start_done)
				|| (state_reg == VSS_ST_PGDLY && !good_done))
				timer_reg <= timer_reg + 20'h00001;
			else
				timer_reg <= 20'h00000;
		end
	end
	assign start_done = (timer_reg == 20'(START_DELAY_CYC - 1));
	assign good_done  = (timer_reg == 20'(GOOD_DELAY_CYC - 1));

	// hiccup wait counted in switching cycles
	always_ff @(posedge mclk) begin
		if (rst) begin
			hic_cnt_reg <= 13'h0000;
		end else if (ce) begin
			if (state_reg != VSS_ST_HICCUP)
				hic_cnt_reg <= 13'h0000;
			else if (sw_rise && !hic_done)
				hic_cnt_reg <= hic_cnt_reg + 13'h0001; // [RULE18]
		end
	end
	assign hic_done = (hic_cnt_reg == 13'(HICCUP_SW));

	// off-code grace period in switching cycles
	always_ff @(posedge mclk) begin
		if (rst) begin
			off_cnt_reg <= 2'h0;
		end else if (ce) begin
			if (state_reg != VSS_ST_OFFWAIT)
				off_cnt_reg <= 2'h0;
			else if (sw_rise && !off_done)
				off_cnt_reg <= off_cnt_reg + 2'h1; // [RULE4]
		end
	end
	assign off_done = (state_reg == VSS_ST_OFFWAIT)
		&& (off_cnt_reg == `VSS_OFF_WAIT_SW);

	// sequencing; losing an enable or an overvoltage overrides all
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= VSS_ST_SHUTDOWN;
		end else if (ce) begin
			if (!en_ok || ovp_latched || ov_s) begin
				state_reg <= VSS_ST_SHUTDOWN; // [RULE15]
			end else begin
				unique case (state_reg)
				VSS_ST_SHUTDOWN: begin
					if (!latched_off && !off_now)
						state_reg <= VSS_ST_DELAY; // [RULE2] [RULE5]
				end
				VSS_ST_DELAY: begin
					if (off_now)
						state_reg <= VSS_ST_SHUTDOWN; // [RULE5]
					else if (start_done)
						state_reg <= VSS_ST_RAMP; // [RULE7]
				end
				VSS_ST_RAMP: begin
					if (oc_event)
						state_reg <= VSS_ST_HICCUP; // [RULE16]
					else if (off_now)
						state_reg <= VSS_ST_OFFWAIT; // [RULE4]
					else if (rif.done)
						state_reg <= VSS_ST_PGDLY;
				end
				VSS_ST_PGDLY: begin
					if (oc_event)
						state_reg <= VSS_ST_HICCUP;
					else if (off_now)
						state_reg <= VSS_ST_OFFWAIT;
					else if (good_done)
						state_reg <= VSS_ST_RUN; // [RULE10]
				end
				VSS_ST_RUN: begin
					if (oc_event)
						state_reg <= VSS_ST_HICCUP; // [RULE18]
					else if (off_now)
						state_reg <= VSS_ST_OFFWAIT; // [RULE4]
				end
				VSS_ST_OFFWAIT: begin
					if (oc_event)
						state_reg <= VSS_ST_HICCUP;
					else if (off_done)
						state_reg <= VSS_ST_SHUTDOWN; // [RULE4]
				end
				VSS_ST_HICCUP: begin
					if (hic_done)
						state_reg <= off_now ? VSS_ST_SHUTDOWN
							: VSS_ST_DELAY; // [RULE18]
				end
				default: state_reg <= VSS_ST_SHUTDOWN;
				endcase
			end
		end
	end

	// ramp target frozen while an off code is on the pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			target_reg <= `VSS_DAC_RST;
		end else if (ce) begin
			if (!off_now)
				target_reg <= code_to_dac(vid_s, dac_offset); // [RULE9]
		end
	end

	// ramp only steps in the ramp state; regulation holds the level
	assign rif.clear  = !is_active(state_reg);
	assign rif.step   = ss_rise && (state_reg == VSS_ST_RAMP); // [RULE8]
	assign rif.target = target_reg;

	vss_ramp u_ramp (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.rif  (rif)
	);

	// phase command; overvoltage beats overcurrent beats normal run
	// the comparator filter adds latency beyond the 20 ns target
	always_ff @(posedge mclk) begin
		if (rst) begin
			pwm_cmd <= VSS_PWM_HIZ;
		end else if (ce) begin
			if (ov_s)
				pwm_cmd <= VSS_PWM_LOW; // [RULE14]
			else if (ovp_latched)
				pwm_cmd <= (pwm_cmd == VSS_PWM_LOW && !rs_low_s)
					? VSS_PWM_LOW : VSS_PWM_HIZ; // [RULE14]
			else if (oc_event || !en_ok)
				pwm_cmd <= VSS_PWM_HIZ; // [RULE18]
			else if (is_active(state_reg) && !off_done)
				pwm_cmd <= VSS_PWM_RUN;
			else
				pwm_cmd <= VSS_PWM_HIZ; // [RULE1]
		end
	end

	// power-good only in regulation with no fault or disable
	always_ff @(posedge mclk) begin
		if (rst) begin
			power_good_out <= 1'b0;
		end else if (ce) begin
			power_good_out <= (state_reg == VSS_ST_RUN) && en_ok
				&& !off_now && !ov_s && !ovp_latched // [RULE11]
				&& !oc_event // [RULE11]
				&& !uv_s; // [RULE12]
		end
	end

	// trip level: fixed level until a valid code regulates
	always_ff @(posedge mclk) begin
		if (rst) begin
			ov_level_vid <= 1'b0;
		end else if (ce) begin
			ov_level_vid <= en_ok && !latched_off && !off_done
				&& (is_active(state_reg)
				|| state_reg == VSS_ST_HICCUP); // [RULE13] [RULE4]
		end
	end

	// registered copies of dac and hiccup status
	always_ff @(posedge mclk) begin
		if (rst) begin
			dac_code  <= `VSS_DAC_RST;
			oc_hiccup <= 1'b0;
		end else if (ce) begin
			dac_code  <= rif.dac;
			oc_hiccup <= (state_reg == VSS_ST_HICCUP);
		end
	end
endmodule

// ==== tb/vss_stage_model.sv ====
`timescale 1ns/1ps
// driver chips plus power stage: output level follows the phase command
module vss_stage_model
	import vss_pkg::*;
(
	input  wire logic     mclk,
	input  wire vss_pwm_e pwm_cmd,
	input  wire logic     ov_force,
	output logic          overvoltage_guard,
	output logic          remote_sense_low
);
	logic [7:0] level_reg = 8'h00;

	// low side on drains slowly, so sensing lags the command on purpose
	always @(posedge mclk) begin
		case (pwm_cmd)
			VSS_PWM_RUN: level_reg <= 8'hc8;
			VSS_PWM_LOW: level_reg <= (level_reg > 8'h04) ?
				level_reg - 8'h04 : 8'h00;
			default: level_reg <= level_reg; // both fets off, level floats
		endcase
	end

	assign remote_sense_low  = level_reg < 8'h28;
	assign overvoltage_guard = ov_force;
endmodule

// ==== tb/vss_sequencer_sva.sv ====
`timescale 1ns/1ps
module vss_sequencer_sva
	import vss_pkg::*;
(
	input wire logic     mclk,
	input wire logic     rst,
	input wire logic     power_enable_in,
	input wire logic     output_sense_low,
	input wire logic     overvoltage_guard,
	input wire logic     average_phase_current,
	input wire vss_pwm_e pwm_cmd,
	input wire vss_dac_t dac_code,
	input wire logic     power_good_out,
	input wire logic     ov_level_vid,
	input wire logic     ovp_latched,
	input wire logic     latched_off,
	input wire logic     oc_hiccup
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// seven cycles covers the input filter plus the state register
	sequence s_ov_held;
		overvoltage_guard [*7];
	endsequence
	sequence s_en_gone;
		!power_enable_in [*7];
	endsequence
	sequence s_uv_held;
		output_sense_low [*7];
	endsequence

	a_idle_no_good: assert property (
		pwm_cmd != VSS_PWM_RUN |-> !power_good_out)
		else $error("good while not switching");
	a_ov_pull_low: assert property (
		s_ov_held |-> pwm_cmd == VSS_PWM_LOW)
		else $error("outputs not low during overvoltage");
	a_ov_stops_run: assert property (
		ovp_latched |-> ##1 pwm_cmd != VSS_PWM_RUN)
		else $error("switching after overvoltage");
	a_enable_gone_off: assert property (
		s_en_gone |-> pwm_cmd != VSS_PWM_RUN && !power_good_out)
		else $error("running without enable");
	a_uv_drops_good: assert property (
		s_uv_held |-> !power_good_out)
		else $error("good during undervoltage");
	a_dac_one_step: assert property (
		dac_code > $past(dac_code) |-> dac_code == $past(dac_code) + 9'h001)
		else $error("dac moved more than one step");
	a_good_id_level: assert property (
		power_good_out |-> ov_level_vid)
		else $error("good with fixed trip level");
	a_oc_goes_hiz: assert property (
		$rose(oc_hiccup) |-> ##[0:1] (pwm_cmd == VSS_PWM_HIZ || ovp_latched))
		else $error("outputs not released on overcurrent");
	a_avg_oc_trip: assert property (
		$rose(average_phase_current) |-> ##[1:8] pwm_cmd != VSS_PWM_RUN)
		else $error("no trip on average overcurrent");
	a_lockout_off: assert property (
		latched_off && $past(latched_off) |-> pwm_cmd != VSS_PWM_RUN)
		else $error("switching while locked out");
endmodule

bind vss_sequencer vss_sequencer_sva u_sva (.mclk, .rst, .power_enable_in,
	.output_sense_low, .overvoltage_guard, .average_phase_current,
	.pwm_cmd, .dac_code, .power_good_out, .ov_level_vid, .ovp_latched,
	.latched_off, .oc_hiccup);

// ==== tb/tb_vss_sequencer.sv ====
`timescale 1ns/1ps
module tb_vss_sequencer;
	import vss_pkg::*;
	localparam int SD = 20;
	localparam int GD = 10;
	localparam int HS = 4;
	localparam vss_dac_t TGT = 9'h096; // 256 - 2*52 - 2
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       por_ok = 1'b0;
	logic       power_enable_in = 1'b0;
	logic       tracking_rail_enable = 1'b0;
	logic [5:0] voltage_id_code = 6'h34;
	logic [7:0] dac_offset = 8'hfe;
	logic       output_sense_low = 1'b0;
	logic       ov_force = 1'b0;
	logic       average_phase_current = 1'b0;
	logic [3:0] channel_overcurrent = 4'h0;
	logic [2:0] osc_div = 3'h0;
	logic       overvoltage_guard, remote_sense_low, power_good_out;
	logic       ov_level_vid, off_code_latched, ovp_latched;
	logic       latched_off, oc_hiccup;
	vss_pwm_e   pwm_cmd;
	vss_dac_t   dac_code;
	int         mismatches = 0;
	int         checked = 0;

	initial begin
		forever #5 mclk = ~mclk;
	end
	// both oscillators slow enough to pass the input filter
	always @(negedge mclk) osc_div <= osc_div + 3'h1;

	vss_sequencer #(.START_DELAY_CYC(SD), .GOOD_DELAY_CYC(GD),
		.HICCUP_SW(HS)) DUT (.mclk, .rst, .ce(1'b1), .por_ok,
		.power_enable_in, .tracking_rail_enable, .voltage_id_code,
		.dac_offset, .output_sense_low, .overvoltage_guard,
		.remote_sense_low, .average_phase_current, .channel_overcurrent,
		.switch_osc(osc_div[2]), .ramp_osc(osc_div[2]), .pwm_cmd,
		.dac_code, .power_good_out, .ov_level_vid, .off_code_latched,
		.ovp_latched, .latched_off, .oc_hiccup);
	vss_stage_model u_stage (.mclk, .pwm_cmd, .ov_force,
		.overvoltage_guard, .remote_sense_low);

	task automatic tally_and_finish();
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk_pwm(input string nm, input vss_pwm_e e,
		input vss_pwm_e g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk_dac(input string nm, input vss_dac_t e,
		input vss_dac_t g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wait_pwm(input vss_pwm_e v, input int lim);
		int n;
		n = 0;
		while (pwm_cmd !== v && n < lim) begin
			cyc(1);
			n++;
		end
		chk_pwm("pwm_wait", v, pwm_cmd);
	endtask
	// start delay, ramp to target, then good after its own delay
	task automatic t_start(input int d);
		int n;
		n = 0;
		cyc(d);
		chk_pwm("pwm_delay", VSS_PWM_HIZ, pwm_cmd);
		wait_pwm(VSS_PWM_RUN, 100);
		chk_bit("ov_level", 1'b1, ov_level_vid);
		while (dac_code !== TGT && n < 3000) begin
			cyc(1);
			n++;
		end
		chk_dac("dac_final", TGT, dac_code);
		chk_bit("ramp_rate", 1'b1, n >= 8 * (TGT - 2));
		n = 0;
		while (power_good_out !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk_bit("good_late", 1'b1, n >= GD);
		chk_bit("good", 1'b1, power_good_out);
	endtask
	task automatic t_retry();
		int n;
		n = 0;
		while (oc_hiccup === 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		t_start(10);
	endtask
	task automatic t_uv();
		output_sense_low = 1'b1;
		cyc(8);
		chk_bit("good_uv", 1'b0, power_good_out);
		output_sense_low = 1'b0;
		cyc(8);
	endtask
	// off code while running, then enabling again with it present
	task automatic t_off(input logic [5:0] code, input logic by_por);
		voltage_id_code = code;
		cyc(6);
		chk_pwm("pwm_offwait", VSS_PWM_RUN, pwm_cmd);
		cyc(30);
		chk_pwm("pwm_off", VSS_PWM_HIZ, pwm_cmd);
		chk_bit("off_latch", 1'b1, off_code_latched);
		chk_bit("ov_lvl_off", 1'b0, ov_level_vid);
		chk_bit("good_off", 1'b0, power_good_out);
		power_enable_in = 1'b0;
		cyc(8);
		power_enable_in = 1'b1;
		cyc(40);
		voltage_id_code = 6'h34;
		cyc(40);
		chk_pwm("pwm_locked", VSS_PWM_HIZ, pwm_cmd);
		chk_bit("lockout", 1'b1, latched_off);
		if (by_por) begin
			por_ok = 1'b0;
		end else begin
			tracking_rail_enable = 1'b0;
		end
		cyc(8);
		por_ok = 1'b1;
		tracking_rail_enable = 1'b1;
		t_start(SD);
	endtask
	task automatic t_ov();
		ov_force = 1'b1;
		cyc(7);
		chk_pwm("pwm_ov", VSS_PWM_LOW, pwm_cmd);
		chk_bit("good_ov", 1'b0, power_good_out);
		ov_force = 1'b0;
		cyc(6);
		chk_pwm("pwm_drain", VSS_PWM_LOW, pwm_cmd);
		wait_pwm(VSS_PWM_HIZ, 200);
		voltage_id_code = 6'h3f;
		cyc(30);
		voltage_id_code = 6'h34;
		cyc(40);
		chk_pwm("pwm_ov_id", VSS_PWM_HIZ, pwm_cmd);
		chk_bit("ov_latch", 1'b1, ovp_latched);
		ov_force = 1'b1;
		cyc(7);
		chk_pwm("pwm_ov_again", VSS_PWM_LOW, pwm_cmd);
		ov_force = 1'b0;
		wait_pwm(VSS_PWM_HIZ, 200);
		tracking_rail_enable = 1'b0;
		cyc(8);
		tracking_rail_enable = 1'b1;
		t_start(SD);
	endtask
	task automatic t_oc_avg();
		average_phase_current = 1'b1;
		cyc(9);
		average_phase_current = 1'b0;
		chk_bit("hiccup", 1'b1, oc_hiccup);
		chk_pwm("pwm_oc", VSS_PWM_HIZ, pwm_cmd);
		cyc(8 * HS - 16);
		chk_bit("hiccup_hold", 1'b1, oc_hiccup);
		t_retry();
	endtask
	// an interrupted run of channel trips must not count
	task automatic t_oc_chan();
		channel_overcurrent = 4'h4;
		cyc(40);
		channel_overcurrent = 4'h0;
		cyc(12);
		channel_overcurrent = 4'h4;
		cyc(40);
		chk_bit("no_trip", 1'b0, oc_hiccup);
		cyc(40);
		chk_bit("chan_trip", 1'b1, oc_hiccup);
		channel_overcurrent = 4'h0;
		t_retry();
	endtask

	initial begin
		// about five times the expected length of all scenarios
		#400000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		cyc(5);
		rst = 1'b0;
		chk_pwm("pwm_rst", VSS_PWM_HIZ, pwm_cmd);
		chk_bit("good_rst", 1'b0, power_good_out);
		por_ok = 1'b1;
		power_enable_in = 1'b1;
		cyc(40);
		chk_pwm("pwm_one_en", VSS_PWM_HIZ, pwm_cmd);
		tracking_rail_enable = 1'b1;
		t_start(SD);
		t_uv();
		t_off(6'h3f, 1'b0);
		t_off(6'h3e, 1'b1);
		t_ov();
		t_oc_avg();
		t_oc_chan();
		tally_and_finish();
	end
endmodule
